//--- src/irl_lockout.sv
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`include "irl_cfg.svh"
`default_nettype none
module irl_lockout
#(
   parameter int CMD_W = 8,
   parameter int BLINK_W = 25,
   parameter logic [BLINK_W-1:0] BLINK_HALF_CYC = BLINK_W'(`IRL_BLINK_HALF_CYC)
)
(
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic [7:0] AXI_AWADDR_IN,
   input wire logic AXI_AWVALID_IN,
   output logic AXI_AWREADY_OUT,
   input wire logic [31:0] AXI_WDATA_IN,
   input wire logic [3:0] AXI_WSTRB_IN,
   input wire logic AXI_WVALID_IN,
   output logic AXI_WREADY_OUT,
   output logic [1:0] AXI_BRESP_OUT,
   output logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic [7:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   output logic AXI_ARREADY_OUT,
   output logic [31:0] AXI_RDATA_OUT,
   output logic [1:0] AXI_RRESP_OUT,
   output logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   input wire logic BUS_SUPPLY_OK_IN,
   input wire logic MOTION_IN,
   input wire logic IR_CMD_VALID_IN,
   input wire logic [CMD_W-1:0] IR_CMD_IN,
   output logic IR_CMD_VALID_OUT,
   output logic [CMD_W-1:0] IR_CMD_OUT,
   output logic MOTION_OUT,
   output logic LAMP_OUT
);
   // ---------------------------------------------------------------
   // supply and motion pin synchronisers
   // ---------------------------------------------------------------
   logic sup_s1_q;
   logic sup_s2_q;
   logic sup_prev_q;
   logic mot_s1_q;
   logic mot_s2_q;

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         sup_s1_q <= 1'b0;
         sup_s2_q <= 1'b0;
         sup_prev_q <= 1'b0;
         mot_s1_q <= 1'b0;
         mot_s2_q <= 1'b0;
      end
      else
      begin
         sup_s1_q <= BUS_SUPPLY_OK_IN;
         sup_s2_q <= sup_s1_q;
         sup_prev_q <= sup_s2_q;
         mot_s1_q <= MOTION_IN;
         mot_s2_q <= mot_s1_q;
      end
   end

   logic sup_rise;
   logic sup_fall;
   assign sup_rise = sup_s2_q && !sup_prev_q;
   assign sup_fall = !sup_s2_q && sup_prev_q;

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic [`IRL_CFG_W-1:0] cfg_q;
   logic [`IRL_CFG_W-1:0] cfg_d;
   logic aw_have_q, aw_have_d;
   logic w_have_q, w_have_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic arready_q, arready_d;
   logic tel_wr;
   logic tel_val;
   logic prog_wr;
   logic lock_q;
   logic lamp;
   logic saved;
   logic inert;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == `IRL_ADDR_CFG) || (a == `IRL_ADDR_TEL) ||
                   (a == `IRL_ADDR_CTRL) || (a == `IRL_ADDR_STAT);
   endfunction

   always_comb
   begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      aw_addr_d = aw_addr_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      cfg_d = cfg_q;
      tel_wr = 1'b0;
      tel_val = 1'b0;
      prog_wr = 1'b0;
      if (AXI_AWVALID_IN && !aw_have_q && !bvalid_q)
      begin
         aw_have_d = 1'b1;
         aw_addr_d = AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && !w_have_q && !bvalid_q)
      begin
         w_have_d = 1'b1;
         w_data_d = AXI_WDATA_IN;
         w_strb_d = AXI_WSTRB_IN;
      end
      if (aw_have_q && w_have_q)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = addr_known(aw_addr_q) ? `IRL_RESP_OKAY : `IRL_RESP_SLVERR;
         if (w_strb_q[0])
         begin
            unique case (aw_addr_q)
               `IRL_ADDR_CFG: cfg_d = w_data_q[`IRL_CFG_W-1:0];
               `IRL_ADDR_TEL:
               begin
                  tel_wr = 1'b1;
                  tel_val = w_data_q[`IRL_TEL_VAL];
               end
               `IRL_ADDR_CTRL: prog_wr = w_data_q[`IRL_CTRL_PROG];
               default: ;
            endcase
         end
      end
      if (bvalid_q && AXI_BREADY_IN)
      begin
         bvalid_d = 1'b0;
      end
      if (rvalid_q && AXI_RREADY_IN)
      begin
         rvalid_d = 1'b0;
      end
      else if (AXI_ARVALID_IN && !rvalid_q)
      begin
         rvalid_d = 1'b1;
         rresp_d = addr_known(AXI_ARADDR_IN) ? `IRL_RESP_OKAY : `IRL_RESP_SLVERR;
         rdata_d = '0;
         unique case (AXI_ARADDR_IN)
            `IRL_ADDR_CFG: rdata_d[`IRL_CFG_W-1:0] = cfg_q;
            `IRL_ADDR_STAT:
            begin
               rdata_d[`IRL_STAT_LOCK] = lock_q;
               rdata_d[`IRL_STAT_LAMP] = lamp;
               rdata_d[`IRL_STAT_INERT] = inert;
               rdata_d[`IRL_STAT_SUPPLY] = sup_s2_q;
               rdata_d[`IRL_STAT_SAVED] = saved;
            end
            default: ;
         endcase
      end
      // readies registered so every port comes from a flop
      awready_d = !aw_have_d && !bvalid_d;
      wready_d = !w_have_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         cfg_q <= `IRL_CFG_RST;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `IRL_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `IRL_RESP_OKAY;
         rdata_q <= 32'h00000000;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
      end
      else
      begin
         cfg_q <= cfg_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_addr_q <= aw_addr_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
      end
   end

   assign AXI_AWREADY_OUT = awready_q;
   assign AXI_WREADY_OUT = wready_q;
   assign AXI_BVALID_OUT = bvalid_q;
   assign AXI_BRESP_OUT = bresp_q;
   assign AXI_ARREADY_OUT = arready_q;
   assign AXI_RVALID_OUT = rvalid_q;
   assign AXI_RRESP_OUT = rresp_q;
   assign AXI_RDATA_OUT = rdata_q;

   // ---------------------------------------------------------------
   // application state and lockout
   // ---------------------------------------------------------------
   irl_pkg::irl_app_t app;
   irl_pkg::irl_ret_t ret;
   logic lock_d;

   assign app = irl_pkg::irl_app_t'(cfg_q[`IRL_CFG_APP_HI:`IRL_CFG_APP_LO]);
   assign ret = irl_pkg::irl_ret_t'(cfg_q[`IRL_CFG_RET_HI:`IRL_CFG_RET_LO]);
   assign inert = (app != irl_pkg::IRL_APP_OK);

   always_comb
   begin
      lock_d = lock_q;
      if (prog_wr)
      begin
         lock_d = cfg_q[`IRL_CFG_PROG];
      end
      else if (sup_rise)
      begin
         unique case (ret)
            irl_pkg::IRL_RET_LOCK: lock_d = 1'b1;
            irl_pkg::IRL_RET_RESTORE: lock_d = saved;
            default: lock_d = 1'b0;
         endcase
      end
      else if (tel_wr && sup_s2_q && !inert)
      begin
         lock_d = (tel_val == cfg_q[`IRL_CFG_POL]);
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         lock_q <= 1'b0;
      end
      else
      begin
         lock_q <= lock_d;
      end
   end

   irl_nv_store u_store
   (
      .clk_in(MCLK_IN),
      .rst_n_in(RST_N_IN),
      .save_in(sup_fall),
      .data_in(lock_q),
      .data_out(saved)
   );

   irl_lamp_blink #(.CNT_W(BLINK_W), .HALF_CYC(BLINK_HALF_CYC)) u_lamp
   (
      .clk_in(MCLK_IN),
      .rst_n_in(RST_N_IN),
      .en_in(inert),
      .lamp_out(lamp)
   );
   assign LAMP_OUT = lamp;

   // ---------------------------------------------------------------
   // gated remote commands and motion
   // ---------------------------------------------------------------
   logic ir_v_q, ir_v_d;
   logic [CMD_W-1:0] ir_c_q, ir_c_d;
   logic mot_q, mot_d;

   always_comb
   begin
      ir_v_d = IR_CMD_VALID_IN && !lock_q && !inert && sup_s2_q;
      ir_c_d = ir_v_d ? IR_CMD_IN : ir_c_q;
      mot_d = mot_s2_q && !inert && sup_s2_q;
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RST_N_IN)
      begin
         ir_v_q <= 1'b0;
         ir_c_q <= '0;
         mot_q <= 1'b0;
      end
      else
      begin
         ir_v_q <= ir_v_d;
         ir_c_q <= ir_c_d;
         mot_q <= mot_d;
      end
   end

   assign IR_CMD_VALID_OUT = ir_v_q;
   assign IR_CMD_OUT = ir_c_q;
   assign MOTION_OUT = mot_q;
endmodule
`default_nettype wire

//--- src/irl_cfg.svh
`ifndef IRL_CFG_SVH
`define IRL_CFG_SVH

// register byte addresses
`define IRL_ADDR_CFG 8'h00
`define IRL_ADDR_TEL 8'h04
`define IRL_ADDR_CTRL 8'h08
`define IRL_ADDR_STAT 8'h0C

// config register fields
`define IRL_CFG_W 6
`define IRL_CFG_RST 6'h00
`define IRL_CFG_POL 0
`define IRL_CFG_RET_LO 1
`define IRL_CFG_RET_HI 2
`define IRL_CFG_PROG 3
`define IRL_CFG_APP_LO 4
`define IRL_CFG_APP_HI 5

// telegram / control / status fields
`define IRL_TEL_VAL 0
`define IRL_CTRL_PROG 0
`define IRL_STAT_LOCK 0
`define IRL_STAT_LAMP 1
`define IRL_STAT_INERT 2
`define IRL_STAT_SUPPLY 3
`define IRL_STAT_SAVED 4

// bus responses
`define IRL_RESP_OKAY 2'h0
`define IRL_RESP_SLVERR 2'h2

// timing: slow lamp flash, half period of a 0.75 Hz blink
`define IRL_CLK_KHZ 25000
`define IRL_BLINK_HALF_MS 666
`define IRL_BLINK_HALF_CYC (`IRL_BLINK_HALF_MS * `IRL_CLK_KHZ)

`endif

//--- src/irl_pkg.sv
`default_nettype none
package irl_pkg;
   typedef enum logic [1:0] {IRL_RET_UNLOCK, IRL_RET_LOCK, IRL_RET_RESTORE} irl_ret_t;
   typedef enum logic [1:0] {IRL_APP_NONE, IRL_APP_OK, IRL_APP_BAD} irl_app_t;
endpackage
`default_nettype wire

//--- src/irl_lamp_blink.sv
`include "irl_cfg.svh"
`default_nettype none
module irl_lamp_blink
#(
   parameter int CNT_W = 25,
   parameter logic [CNT_W-1:0] HALF_CYC = CNT_W'(`IRL_BLINK_HALF_CYC)
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   output logic lamp_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic lamp_q;
   logic lamp_d;

   always_comb
   begin
      cnt_d = cnt_q;
      lamp_d = lamp_q;
      if (!en_in)
      begin
         cnt_d = '0;
         lamp_d = 1'b0;
      end
      else if (cnt_q >= HALF_CYC - CNT_W'(1))
      begin
         cnt_d = '0;
         lamp_d = !lamp_q;
      end
      else
      begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         cnt_q <= '0;
         lamp_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         lamp_q <= lamp_d;
      end
   end

   assign lamp_out = lamp_q;
endmodule
`default_nettype wire

//--- src/irl_nv_store.sv
`default_nettype none
module irl_nv_store
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic save_in,
   input wire logic data_in,
   output logic data_out
);
   // retained lockout state across a supply loss
   logic saved_q;
   logic saved_d;

   always_comb
   begin
      saved_d = save_in ? data_in : saved_q;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         saved_q <= 1'b0;
      end
      else
      begin
         saved_q <= saved_d;
      end
   end

   assign data_out = saved_q;
endmodule
`default_nettype wire

//--- sim/irl_lockout_checker.sv
`default_nettype none
module irl_lockout_checker
#(
   parameter int CMD_W = 8
)
(
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic AXI_AWVALID_IN,
   input wire logic AXI_AWREADY_OUT,
   input wire logic AXI_WVALID_IN,
   input wire logic AXI_WREADY_OUT,
   input wire logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic [7:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   input wire logic AXI_ARREADY_OUT,
   input wire logic [31:0] AXI_RDATA_OUT,
   input wire logic [1:0] AXI_RRESP_OUT,
   input wire logic AXI_RVALID_OUT,
   input wire logic IR_CMD_VALID_IN,
   input wire logic [CMD_W-1:0] IR_CMD_IN,
   input wire logic IR_CMD_VALID_OUT,
   input wire logic [CMD_W-1:0] IR_CMD_OUT,
   input wire logic LAMP_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   ir_pass_a: assert property (IR_CMD_VALID_OUT |-> $past(IR_CMD_VALID_IN)) else $error("ir pass");
   ir_code_a: assert property (IR_CMD_VALID_OUT |-> IR_CMD_OUT == $past(IR_CMD_IN)) else $error("ir code");
   lamp_ir_a: assert property (IR_CMD_VALID_OUT |-> !LAMP_OUT) else $error("lamp while active");
   wr_busy_a: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT) else $error("wr ready");
   wr_answer_a: assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT
      |-> ##2 AXI_BVALID_OUT) else $error("wr answer");
   b_done_a: assert property (AXI_BVALID_OUT && AXI_BREADY_IN |=> !AXI_BVALID_OUT) else $error("b done");
   rd_answer_a: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT)
      else $error("rd answer");
   bad_addr_a: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT && AXI_ARADDR_IN > 8'h0C
      |=> AXI_RRESP_OUT == 2'h2 && AXI_RDATA_OUT == 32'h0) else $error("bad addr");
   ir_seen_c: cover property (IR_CMD_VALID_OUT);
   lamp_c: cover property ($rose(LAMP_OUT));
   err_c: cover property (AXI_RVALID_OUT && AXI_RRESP_OUT == 2'h2);
endmodule
bind irl_lockout irl_lockout_checker #(.CMD_W(CMD_W)) u_chk (
   .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
   .AXI_WVALID_IN(AXI_WVALID_IN), .AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BVALID_OUT(AXI_BVALID_OUT),
   .AXI_BREADY_IN(AXI_BREADY_IN), .AXI_ARADDR_IN(AXI_ARADDR_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
   .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT), .AXI_RRESP_OUT(AXI_RRESP_OUT),
   .AXI_RVALID_OUT(AXI_RVALID_OUT), .IR_CMD_VALID_IN(IR_CMD_VALID_IN), .IR_CMD_IN(IR_CMD_IN),
   .IR_CMD_VALID_OUT(IR_CMD_VALID_OUT), .IR_CMD_OUT(IR_CMD_OUT), .LAMP_OUT(LAMP_OUT));
`default_nettype wire

//--- sim/irl_remote.sv
`default_nettype none
module irl_remote
(
   input wire logic clk_in,
   input wire logic send_in,
   input wire logic [7:0] code_in,
   output logic valid_out,
   output logic [7:0] cmd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      valid_out = 1'h0;
      cmd_out = 8'h00;
   end
   // one pulse per key press; code is garbage between presses
   always @(posedge clk_in)
   begin
      valid_out <= send_in;
      cmd_out <= send_in ? code_in : ~cmd_out;
   end
endmodule
`default_nettype wire

//--- sim/testbench.sv
`include "irl_cfg.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] awa = 8'h00, ara = 8'h00, code = 8'h00, ic, io;
   logic [31:0] wd = 32'h0, rdat, rd_v;
   logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, sup = 1'h1, mot = 1'h0, snd = 1'h0;
   logic awr, wr, bv, arr, rv, ivi, ivo, mo, lamp;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] cfg_t [5] = '{32'h11, 32'h13, 32'h15, 32'h15, 32'h17};
   logic [4:0] pre_t = 5'h15, exp_t = 5'h06;
   int n_mismatch = 0, checks = 0, n_pass = 0;
   irl_lockout #(.CMD_W(8), .BLINK_W(25), .BLINK_HALF_CYC(25'h0000008)) uut (
      .MCLK_IN(clk), .RST_N_IN(rst_n), .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
      .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr), .AXI_BRESP_OUT(bresp),
      .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(br), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
      .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rr),
      .BUS_SUPPLY_OK_IN(sup), .MOTION_IN(mot), .IR_CMD_VALID_IN(ivi), .IR_CMD_IN(ic), .IR_CMD_VALID_OUT(ivo),
      .IR_CMD_OUT(io), .MOTION_OUT(mo), .LAMP_OUT(lamp));
   irl_remote u_rem (.clk_in(clk), .send_in(snd), .code_in(code), .valid_out(ivi), .cmd_out(ic));
   initial forever #20 clk = ~clk;
   always @(posedge clk) if (ivo) n_pass <= n_pass + 1;
   // ----------------
   // tasks
   // ----------------
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task wt(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr) wv <= 1'h0;
      end
      while (bv !== 1'h1);
      br <= 1'h0;
      chk("wr resp", {30'h0, bresp}, 32'h0);
   endtask
   task rdt(input logic [7:0] a);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end
      while (rv !== 1'h1);
      rr <= 1'h0;
      rd_v = rdat;
      resp = rresp;
   endtask
   task st(input logic [31:0] m, input logic [31:0] e);
      rdt(`IRL_ADDR_STAT);
      chk("status", rd_v & m, e);
   endtask
   task ir(input logic [7:0] c, input int e);
      int p;
      p = n_pass;
      @(posedge clk);
      code <= c;
      snd <= 1'h1;
      @(posedge clk);
      snd <= 1'h0;
      repeat (4) @(posedge clk);
      chk("ir count", n_pass - p, e);
      if (e) chk("ir code", {24'h0, io}, {24'h0, c});
   endtask
   task mv(input logic e);
      mot <= 1'h1;
      repeat (6) @(posedge clk);
      chk("motion", {31'h0, mo}, {31'h0, e});
      mot <= 1'h0;
   endtask
   task blink;
      do @(posedge clk); while (lamp !== 1'h0);
      do @(posedge clk); while (lamp !== 1'h1);
      repeat (7) @(posedge clk);
      chk("lamp high", {31'h0, lamp}, 32'h1);
      @(posedge clk);
      chk("lamp low", {31'h0, lamp}, 32'h0);
   endtask
   task test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------
   // tests
   // ----------------
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      repeat (6) @(posedge clk);
      st(32'h0000000D, 32'h0000000C);
      ir(8'hA5, 0);
      mv(1'h0);
      blink;
      rdt(8'h10);
      chk("bad data", rd_v, 32'h0);
      chk("bad resp", {30'h0, resp}, {30'h0, `IRL_RESP_SLVERR});
      wt(`IRL_ADDR_CFG, 32'h11);
      rdt(`IRL_ADDR_CFG);
      chk("config", rd_v, 32'h11);
      st(32'h0000000D, 32'h00000008);
      ir(8'h3C, 1);
      mv(1'h1);
      wt(`IRL_ADDR_TEL, 32'h1);
      st(32'h1, 32'h1);
      ir(8'h5A, 0);
      wt(`IRL_ADDR_TEL, 32'h1);
      st(32'h1, 32'h1);
      wt(`IRL_ADDR_TEL, 32'h0);
      ir(8'hC3, 1);
      wt(`IRL_ADDR_CFG, 32'h10);
      wt(`IRL_ADDR_TEL, 32'h0);
      st(32'h1, 32'h1);
      wt(`IRL_ADDR_TEL, 32'h1);
      st(32'h1, 32'h0);
      wt(`IRL_ADDR_CFG, 32'h18);
      wt(`IRL_ADDR_CTRL, 32'h1);
      st(32'h1, 32'h1);
      wt(`IRL_ADDR_CFG, 32'h11);
      wt(`IRL_ADDR_CTRL, 32'h1);
      st(32'h1, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         wt(`IRL_ADDR_CFG, cfg_t[i]);
         wt(`IRL_ADDR_TEL, {31'h0, pre_t[i]});
         sup <= 1'h0;
         repeat (8) @(posedge clk);
         sup <= 1'h1;
         repeat (8) @(posedge clk);
         st(32'h11, {27'h0, pre_t[i], 3'h0, exp_t[i]});
      end
      wt(`IRL_ADDR_CFG, 32'h21);
      st(32'h4, 32'h4);
      wt(`IRL_ADDR_TEL, 32'h1);
      st(32'h1, 32'h0);
      ir(8'h99, 0);
      mv(1'h0);
      blink;
      test_done;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      test_done;
   end
endmodule
`default_nettype wire
